// *** tlsr_pkg.sv ***
// Register map, field layout and decoders for the temperature limit status bank
//****************************************************************************
//****************************************************************************
package tlsr_pkg;

  //****************************************************************************
  // Register offsets
  //****************************************************************************
  localparam logic [7:0] TLSR_ADDR_HIGH = 8'h35;
  localparam logic [7:0] TLSR_ADDR_LOW = 8'h36;
  localparam logic [7:0] TLSR_ADDR_SHUTDOWN = 8'h37;
  localparam logic [7:0] TLSR_ADDR_FILTER = 8'h40;
  localparam logic [7:0] TLSR_ADDR_PRODUCT = 8'hFD;
  localparam logic [7:0] TLSR_ADDR_MAKER = 8'hFE;
  localparam logic [7:0] TLSR_ADDR_REVISION = 8'hFF;

  //****************************************************************************
  // Fields and reset values
  //****************************************************************************
  localparam int TLSR_FLAG_BITS = 4;
  localparam int TLSR_FILTER_BITS = 2;
  localparam logic [3:0] TLSR_FLAGS_RESET = 4'h0;
  localparam logic [1:0] TLSR_FILTER_RESET = 2'h0;
  localparam logic [7:0] TLSR_READ_IDLE = 8'h00;
  localparam logic [2:0] TLSR_COUNT_ZERO = 3'h0;
  localparam logic [2:0] TLSR_COUNT_ONE = 3'h1;

  // Identification codes, values arbitrary
  localparam logic [7:0] TLSR_PRODUCT_3CH = 8'hA3;
  localparam logic [7:0] TLSR_PRODUCT_4CH = 8'hA4;
  localparam logic [7:0] TLSR_MAKER_CODE = 8'h3C;
  localparam logic [7:0] TLSR_REVISION_CODE = 8'h02;

  typedef enum logic [1:0] {
    TLSR_FILT_OFF = 2'b00,
    TLSR_FILT_LEVEL1 = 2'b01,
    TLSR_FILT_LEVEL2 = 2'b10
  } tlsr_filter_t;

  function automatic logic [2:0] tlsr_consec_decode(input logic [2:0] field);
    case (field)
      3'h0: tlsr_consec_decode = 3'h1;
      3'h1: tlsr_consec_decode = 3'h2;
      3'h3: tlsr_consec_decode = 3'h3;
      3'h7: tlsr_consec_decode = 3'h4;
      default: tlsr_consec_decode = 3'h1;
    endcase
  endfunction

  function automatic tlsr_filter_t tlsr_filter_decode(input logic [1:0] field);
    case (field)
      2'h0: tlsr_filter_decode = TLSR_FILT_OFF;
      2'h1: tlsr_filter_decode = TLSR_FILT_LEVEL1;
      2'h2: tlsr_filter_decode = TLSR_FILT_LEVEL1;
      default: tlsr_filter_decode = TLSR_FILT_LEVEL2;
    endcase
  endfunction

endpackage

// *** tlsr_consec_counter.sv ***
// Per-channel consecutive out-of-limit measurement counter
`timescale 1ns/1ps
module tlsr_consec_counter
  import tlsr_pkg::*;
#(
  parameter bit RESTART = 1'b1
) (
  input wire logic clk_in,        // System clock
  input wire logic sys_rst_in,    // Synchronous reset, active high
  input wire logic step_in,       // Conversion result valid pulse
  input wire logic hit_in,        // Out of limit this conversion
  input wire logic keep_in,       // Hold count on an in-limit result
  input wire logic [2:0] field_in, // Consecutive count field
  output logic reached_out        // Count met on this step
);

  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic [2:0] need;
  logic [2:0] count_inc;

  assign need = tlsr_consec_decode(field_in);
  assign count_inc = (count_reg >= need) ? need : count_reg + TLSR_COUNT_ONE;
  assign reached_out = step_in & hit_in & (count_inc >= need);

  always_comb begin
    count_next = count_reg;
    if (step_in && hit_in) begin
      count_next = (reached_out && RESTART) ? TLSR_COUNT_ZERO : count_inc;
    end else if (step_in && !keep_in) begin
      count_next = TLSR_COUNT_ZERO;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_reg <= TLSR_COUNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  //****************************************************************************
  // Checks
  //****************************************************************************
  property p_count_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
    (step_in && !hit_in && keep_in) |=> $stable(count_reg);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved while held");

  property p_count_drop;
    @(posedge clk_in) disable iff (sys_rst_in)
    (step_in && !hit_in && !keep_in) |=> (count_reg == TLSR_COUNT_ZERO);
  endproperty
  a_count_drop: assert property (p_count_drop) else $error("counter not reset in limit");

endmodule

// *** tlsr_flag_bank.sv ***
// Bank of sticky status flags with set-over-clear priority
`timescale 1ns/1ps
module tlsr_flag_bank
  import tlsr_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,             // System clock
  input wire logic sys_rst_in,         // Synchronous reset, active high
  input wire logic [WIDTH-1:0] set_in, // Per-bit set events
  input wire logic [WIDTH-1:0] drop_in, // Per-bit clear conditions
  input wire logic clear_in,           // Clear all bits
  output logic [WIDTH-1:0] flags_out   // Flag state
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // Set wins over any clear in the same cycle
  assign flags_next = set_in | (flags_reg & ~drop_in & ~{WIDTH{clear_in}});
  assign flags_out = flags_reg;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags_reg <= TLSR_FLAGS_RESET[WIDTH-1:0];
    end else begin
      flags_reg <= flags_next;
    end
  end

  property p_set_wins;
    @(posedge clk_in) disable iff (sys_rst_in)
    (clear_in && (set_in != '0)) |=> ((flags_out & $past(set_in)) == $past(set_in));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost against clear");

endmodule

// *** tlsr_status_regs.sv ***
// Limit status flags, alert and shutdown outputs, filter and identification registers
`timescale 1ns/1ps
module tlsr_status_regs
  import tlsr_pkg::*;
#(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic clk_in,                                // System clock, 10 MHz
  input wire logic sys_rst_in,                            // Synchronous reset, active high
  input wire logic [7:0] reg_addr_in,                     // Register pointer
  input wire logic reg_wr_in,                             // Register write strobe
  input wire logic reg_rd_in,                             // Register read strobe
  input wire logic [7:0] reg_wdata_in,                    // Write data
  output logic [7:0] reg_rdata_out,                       // Read data, valid after strobe
  input wire logic meas_valid_in,                         // Conversion results valid pulse
  input wire logic [NUM_CHANNELS-1:0] over_high_in,       // Above high limit
  input wire logic [NUM_CHANNELS-1:0] under_low_in,       // Below low limit
  input wire logic [NUM_CHANNELS-1:0] diode_fault_in,     // Diode fault seen
  input wire logic [NUM_CHANNELS-1:0] over_shutdown_in,   // Above shutdown limit
  input wire logic [NUM_CHANNELS-1:0] below_shutdown_hyst_in, // Below limit minus hysteresis
  input wire logic [2:0] alert_consecutive_count_in,      // Alert count field
  input wire logic [2:0] shutdown_consecutive_count_in,   // Shutdown count field
  input wire logic comparator_mode_in,                    // Alert in comparator mode
  output logic alert_n_out,                               // Alert output, active low
  output logic shutdown_n_out,                            // Thermal shutdown output, active low
  output logic status_high_out,                           // High summary status bit
  output logic status_low_out,                            // Low summary status bit
  output logic status_shutdown_out,                       // Shutdown summary status bit
  output tlsr_filter_t filter_level_out                   // Filter level, first external channel
);

  //****************************************************************************
  // Address decode
  //****************************************************************************
  function automatic logic tlsr_hit(input logic [7:0] addr, input logic [7:0] target);
    tlsr_hit = (addr == target);
  endfunction

  localparam logic [7:0] PRODUCT_CODE = (NUM_CHANNELS > 3) ? TLSR_PRODUCT_4CH : TLSR_PRODUCT_3CH;

  logic rd_high;
  logic rd_low;
  logic rd_shutdown;
  logic rd_filter;
  logic rd_product;
  logic rd_maker;
  logic rd_revision;
  logic wr_filter;

  assign rd_high = reg_rd_in & tlsr_hit(reg_addr_in, TLSR_ADDR_HIGH);
  assign rd_low = reg_rd_in & tlsr_hit(reg_addr_in, TLSR_ADDR_LOW);
  assign rd_shutdown = reg_rd_in & tlsr_hit(reg_addr_in, TLSR_ADDR_SHUTDOWN);
  assign rd_filter = reg_rd_in & tlsr_hit(reg_addr_in, TLSR_ADDR_FILTER);
  assign rd_product = reg_rd_in & tlsr_hit(reg_addr_in, TLSR_ADDR_PRODUCT);
  assign rd_maker = reg_rd_in & tlsr_hit(reg_addr_in, TLSR_ADDR_MAKER);
  assign rd_revision = reg_rd_in & tlsr_hit(reg_addr_in, TLSR_ADDR_REVISION);
  assign wr_filter = reg_wr_in & tlsr_hit(reg_addr_in, TLSR_ADDR_FILTER);

  //****************************************************************************
  // Per-channel consecutive counters
  //****************************************************************************
  logic [NUM_CHANNELS-1:0] alert_reached;
  logic [NUM_CHANNELS-1:0] shutdown_reached;
  logic [NUM_CHANNELS-1:0] alert_hit;
  logic [NUM_CHANNELS-1:0] shutdown_keep;
  logic [NUM_CHANNELS-1:0] high_flags;
  logic [NUM_CHANNELS-1:0] low_flags;
  logic [NUM_CHANNELS-1:0] shutdown_flags;

  assign alert_hit = over_high_in | under_low_in | diode_fault_in;
  // Once asserted, only a drop below limit minus hysteresis resets the count
  assign shutdown_keep = shutdown_flags & ~below_shutdown_hyst_in;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      tlsr_consec_counter #(
        .RESTART(1'b1)
      ) u_alert_count (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .step_in(meas_valid_in),
        .hit_in(alert_hit[ch]),
        .keep_in(1'b0),
        .field_in(alert_consecutive_count_in),
        .reached_out(alert_reached[ch])
      );

      tlsr_consec_counter #(
        .RESTART(1'b0)
      ) u_shutdown_count (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .step_in(meas_valid_in),
        .hit_in(over_shutdown_in[ch]),
        .keep_in(shutdown_keep[ch]),
        .field_in(shutdown_consecutive_count_in),
        .reached_out(shutdown_reached[ch])
      );
    end
  endgenerate

  //****************************************************************************
  // Flag banks
  //****************************************************************************
  logic [NUM_CHANNELS-1:0] high_set;
  logic [NUM_CHANNELS-1:0] low_set;
  logic [NUM_CHANNELS-1:0] high_drop;
  logic [NUM_CHANNELS-1:0] low_drop;
  logic [NUM_CHANNELS-1:0] shutdown_drop;

  // Flags only set when the channel's count is met, so alert waits for the count
  assign high_set = alert_reached & over_high_in;
  assign low_set = alert_reached & under_low_in;
  // Comparator mode follows each new result instead of latching
  assign high_drop = {NUM_CHANNELS{comparator_mode_in & meas_valid_in}} & ~over_high_in;
  assign low_drop = {NUM_CHANNELS{comparator_mode_in & meas_valid_in}} & ~under_low_in;
  assign shutdown_drop = below_shutdown_hyst_in;

  tlsr_flag_bank #(
    .WIDTH(NUM_CHANNELS)
  ) u_high_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(high_set),
    .drop_in(high_drop),
    .clear_in(rd_high),
    .flags_out(high_flags)
  );

  tlsr_flag_bank #(
    .WIDTH(NUM_CHANNELS)
  ) u_low_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(low_set),
    .drop_in(low_drop),
    .clear_in(rd_low),
    .flags_out(low_flags)
  );

  // Reads never clear these
  tlsr_flag_bank #(
    .WIDTH(NUM_CHANNELS)
  ) u_shutdown_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(shutdown_reached),
    .drop_in(shutdown_drop),
    .clear_in(1'b0),
    .flags_out(shutdown_flags)
  );

  //****************************************************************************
  // Summary bits and outputs
  //****************************************************************************
  logic alert_n_reg;
  logic shutdown_n_reg;
  logic [TLSR_FILTER_BITS-1:0] filter_reg;
  logic [7:0] rdata_reg;
  logic [7:0] read_mux;
  logic [TLSR_FLAG_BITS-1:0] high_view;
  logic [TLSR_FLAG_BITS-1:0] low_view;
  logic [TLSR_FLAG_BITS-1:0] shutdown_view;

  assign status_high_out = |high_flags;
  assign status_low_out = |low_flags;
  assign status_shutdown_out = |shutdown_flags;
  assign alert_n_out = alert_n_reg;
  assign shutdown_n_out = shutdown_n_reg;
  assign filter_level_out = tlsr_filter_decode(filter_reg);
  assign reg_rdata_out = rdata_reg;

  assign high_view = TLSR_FLAG_BITS'(high_flags);
  assign low_view = TLSR_FLAG_BITS'(low_flags);
  assign shutdown_view = TLSR_FLAG_BITS'(shutdown_flags);

  // Upper bits and unmapped offsets read as zero
  assign read_mux = rd_high ? {4'h0, high_view} :
                    rd_low ? {4'h0, low_view} :
                    rd_shutdown ? {4'h0, shutdown_view} :
                    rd_filter ? {6'h00, filter_reg} :
                    rd_product ? PRODUCT_CODE :
                    rd_maker ? TLSR_MAKER_CODE :
                    rd_revision ? TLSR_REVISION_CODE :
                    TLSR_READ_IDLE;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      alert_n_reg <= 1'b1;
      shutdown_n_reg <= 1'b1;
    end else begin
      alert_n_reg <= ~(|high_flags | |low_flags);
      shutdown_n_reg <= ~(|shutdown_flags);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      filter_reg <= TLSR_FILTER_RESET;
    end else if (wr_filter) begin
      filter_reg <= reg_wdata_in[TLSR_FILTER_BITS-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= TLSR_READ_IDLE;
    end else if (reg_rd_in) begin
      rdata_reg <= read_mux;
    end
  end

  //****************************************************************************
  // Checks
  //****************************************************************************
  default clocking cb_main @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_filter_write(logic [1:0] code);
    wr_filter && (reg_wdata_in[1:0] == code);
  endsequence

  sequence s_no_filter_write;
    !wr_filter;
  endsequence

  property p_high_set;
    (high_set != '0) |=> ((high_flags & $past(high_set)) == $past(high_set));
  endproperty
  a_high_set: assert property (p_high_set) else $error("high flag not set");

  property p_high_summary;
    (high_set != '0) |=> status_high_out ##1 (status_high_out || $past(rd_high));
  endproperty
  a_high_summary: assert property (p_high_summary) else $error("high summary missing");

  property p_high_clear;
    (rd_high && (high_set == '0)) |=> (high_flags == '0) && !status_high_out;
  endproperty
  a_high_clear: assert property (p_high_clear) else $error("high read did not clear");

  property p_alert_cause;
    !alert_n_out |-> $past(status_high_out || status_low_out);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without flag");

  property p_alert_follow;
    (status_high_out || status_low_out) |=> !alert_n_out;
  endproperty
  a_alert_follow: assert property (p_alert_follow) else $error("alert not asserted");

  property p_latch;
    (!comparator_mode_in && !rd_high) |=> ((high_flags & $past(high_flags)) == $past(high_flags));
  endproperty
  a_latch: assert property (p_latch) else $error("high flag lost while latched");

  property p_low_clear;
    (rd_low && (low_set == '0)) |=> (low_flags == '0) && !status_low_out;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low read did not clear");

  property p_shutdown_read;
    (rd_shutdown && (shutdown_drop == '0) && (shutdown_reached == '0)) |=> $stable(shutdown_flags);
  endproperty
  a_shutdown_read: assert property (p_shutdown_read) else $error("shutdown flags changed on read");

  property p_shutdown_autoclear;
    ((shutdown_drop & ~shutdown_reached) != '0) |=>
      ((shutdown_flags & $past(shutdown_drop & ~shutdown_reached)) == '0);
  endproperty
  a_shutdown_autoclear: assert property (p_shutdown_autoclear) else $error("shutdown flag kept");

  property p_shutdown_pin;
    status_shutdown_out |=> !shutdown_n_out;
  endproperty
  a_shutdown_pin: assert property (p_shutdown_pin) else $error("shutdown output idle");

  property p_filter_level2;
    s_filter_write(2'b11) ##1 s_no_filter_write |-> (filter_level_out == TLSR_FILT_LEVEL2);
  endproperty
  a_filter_level2: assert property (p_filter_level2) else $error("filter level 2 not decoded");

  property p_filter_level1;
    s_filter_write(2'b10) |=> (filter_level_out == TLSR_FILT_LEVEL1);
  endproperty
  a_filter_level1: assert property (p_filter_level1) else $error("filter level 1 not decoded");

  property p_product;
    rd_product |=> (reg_rdata_out == PRODUCT_CODE);
  endproperty
  a_product: assert property (p_product) else $error("product code wrong");

  property p_maker;
    rd_maker |=> (reg_rdata_out == TLSR_MAKER_CODE);
  endproperty
  a_maker: assert property (p_maker) else $error("maker code wrong");

  property p_upper_zero;
    (rd_high || rd_low || rd_shutdown) |=> (reg_rdata_out[7:4] == 4'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

  property p_low_set;
    (low_set != '0) |=> ((low_flags & $past(low_set)) == $past(low_set));
  endproperty
  a_low_set: assert property (p_low_set) else $error("low flag not set");

  property p_low_summary;
    (low_set != '0) |=> status_low_out;
  endproperty
  a_low_summary: assert property (p_low_summary) else $error("low summary missing");

  property p_low_latch;
    (!comparator_mode_in && !rd_low) |=> ((low_flags & $past(low_flags)) == $past(low_flags));
  endproperty
  a_low_latch: assert property (p_low_latch) else $error("low flag lost while latched");

  property p_compare_drop;
    (comparator_mode_in && meas_valid_in) |=> ((high_flags & ~$past(over_high_in)) == '0);
  endproperty
  a_compare_drop: assert property (p_compare_drop) else $error("comparator flag kept");

  property p_shutdown_set;
    (shutdown_reached != '0) |=> ((shutdown_flags & $past(shutdown_reached)) == $past(shutdown_reached));
  endproperty
  a_shutdown_set: assert property (p_shutdown_set) else $error("shutdown flag not set");

  property p_shutdown_release;
    !status_shutdown_out |=> shutdown_n_out;
  endproperty
  a_shutdown_release: assert property (p_shutdown_release) else $error("shutdown output stuck");

  property p_alert_release;
    !(status_high_out || status_low_out) |=> alert_n_out;
  endproperty
  a_alert_release: assert property (p_alert_release) else $error("alert output stuck");

  property p_revision;
    rd_revision |=> (reg_rdata_out == TLSR_REVISION_CODE);
  endproperty
  a_revision: assert property (p_revision) else $error("revision code wrong");

  property p_filter_upper;
    rd_filter |=> (reg_rdata_out[7:2] == 6'h00);
  endproperty
  a_filter_upper: assert property (p_filter_upper) else $error("filter upper bits not zero");

  property p_read_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");

endmodule

// *** tlsr_host_model.sv ***
// Host side model driving the register strobe interface of the status bank
`timescale 1ns/1ps
module tlsr_host_model (
  input wire logic clk_in,          // System clock
  input wire logic [7:0] rdata_in,  // Read data from the device
  output logic [7:0] addr_out,      // Register pointer
  output logic rd_out,              // Read strobe
  output logic wr_out,              // Write strobe
  output logic [7:0] wdata_out      // Write data
);
  initial begin
    addr_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end

  //****************************************************************************
  // One-cycle strobes, launched just after a rising edge
  //****************************************************************************
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    // Stale data must not look valid
    wdata_out = ~d;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    d = rdata_in;
  endtask
endmodule

// *** temp_limit_status_regs_tb.sv ***
// Self-checking testbench for the temperature limit status bank
`timescale 1ns/1ps
module temp_limit_status_regs_tb;
  import tlsr_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr, wdata, rdata, d;
  logic rd, wr, meas_v = 1'b0, cm = 1'b0;
  logic [3:0] oh = 4'h0, ul = 4'h0, df = 4'h0, os = 4'h0, bh = 4'h0;
  logic [2:0] ac = 3'h0, sc = 3'h0;
  logic alert_n, shut_n, st_high, st_low, st_shut;
  tlsr_filter_t filt;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [2:0] fld [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  tlsr_host_model u_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .rd_out(rd), .wr_out(wr),
    .wdata_out(wdata));

  tlsr_status_regs #(.NUM_CHANNELS(4)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .meas_valid_in(meas_v),
    .over_high_in(oh), .under_low_in(ul), .diode_fault_in(df), .over_shutdown_in(os),
    .below_shutdown_hyst_in(bh), .alert_consecutive_count_in(ac), .shutdown_consecutive_count_in(sc),
    .comparator_mode_in(cm), .alert_n_out(alert_n), .shutdown_n_out(shut_n), .status_high_out(st_high),
    .status_low_out(st_low), .status_shutdown_out(st_shut), .filter_level_out(filt));

  //****************************************************************************
  // Helpers
  //****************************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host.reg_read(a, v);
    chk(v, exp, $sformatf("register %h", a));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic meas(input logic [3:0] h, input logic [3:0] l, input logic [3:0] s);
    @(posedge clk_in);
    #1;
    oh = h;
    ul = l;
    os = s;
    meas_v = 1'b1;
    @(posedge clk_in);
    #1;
    meas_v = 1'b0;
    oh = 4'h0;
    ul = 4'h0;
    os = 4'h0;
  endtask

  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  //****************************************************************************
  // Main sequence
  //****************************************************************************
  initial begin
    cyc(20);
    sys_rst_in = 1'b0;
    rchk(TLSR_ADDR_HIGH, 8'h00);
    rchk(TLSR_ADDR_LOW, 8'h00);
    rchk(TLSR_ADDR_SHUTDOWN, 8'h00);
    rchk(TLSR_ADDR_FILTER, 8'h00);
    rchk(TLSR_ADDR_PRODUCT, TLSR_PRODUCT_4CH);
    rchk(TLSR_ADDR_MAKER, TLSR_MAKER_CODE);
    rchk(TLSR_ADDR_REVISION, TLSR_REVISION_CODE);
    rchk(8'h10, 8'h00);
    chk({7'h0, alert_n & shut_n}, 8'h01, "idle outputs");
    $display("test reset values done");
    for (int v = 0; v < 4; v++) begin
      u_host.reg_write(TLSR_ADDR_FILTER, 8'hFC | 8'(v));
      rchk(TLSR_ADDR_FILTER, 8'(v));
      chk({6'h0, filt}, (v == 0) ? 8'h00 : (v == 3) ? 8'h02 : 8'h01, "filter level");
    end
    u_host.reg_write(TLSR_ADDR_HIGH, 8'hFF);
    rchk(TLSR_ADDR_HIGH, 8'h00);
    $display("test filter done");
    for (int i = 0; i < 2; i++) begin
      meas(i ? 4'h0 : 4'hA, i ? 4'h5 : 4'h0, 4'h0);
      meas(4'h0, 4'h0, 4'h0);
      cyc(1);
      chk({6'h0, st_high, st_low}, i ? 8'h01 : 8'h02, "summary set");
      chk({7'h0, alert_n}, 8'h00, "alert on");
      rchk(i ? TLSR_ADDR_LOW : TLSR_ADDR_HIGH, i ? 8'h05 : 8'h0A);
      rchk(i ? TLSR_ADDR_LOW : TLSR_ADDR_HIGH, 8'h00);
      chk({6'h0, st_high, st_low}, 8'h00, "summary cleared");
      chk({7'h0, alert_n}, 8'h01, "alert off");
    end
    $display("test high and low flags done");
    for (int j = 0; j < 4; j++) begin
      ac = fld[j];
      for (int k = 1; k <= j + 1; k++) begin
        meas(4'h1, 4'h0, 4'h0);
        chk({7'h0, st_high}, (k == j + 1) ? 8'h01 : 8'h00, "count step");
      end
      cyc(1);
      chk({7'h0, alert_n}, 8'h00, "alert after count");
      rchk(TLSR_ADDR_HIGH, 8'h01);
    end
    ac = fld[1];
    df = 4'h1;
    meas(4'h0, 4'h0, 4'h0);
    df = 4'h0;
    chk({7'h0, st_high}, 8'h00, "fault no flag");
    meas(4'h1, 4'h0, 4'h0);
    chk({7'h0, st_high}, 8'h01, "fault counts");
    rchk(TLSR_ADDR_HIGH, 8'h01);
    ac = 3'h0;
    $display("test consecutive counts done");
    meas(4'h0, 4'h0, 4'h2);
    meas(4'h0, 4'h0, 4'h8);
    cyc(1);
    rchk(TLSR_ADDR_SHUTDOWN, 8'h0A);
    rchk(TLSR_ADDR_SHUTDOWN, 8'h0A);
    chk({6'h0, st_shut, shut_n}, 8'h02, "shutdown on");
    bh = 4'h2;
    cyc(2);
    rchk(TLSR_ADDR_SHUTDOWN, 8'h08);
    chk({6'h0, st_shut, shut_n}, 8'h02, "summary held");
    bh = 4'hF;
    cyc(2);
    chk({6'h0, st_shut, shut_n}, 8'h01, "shutdown off");
    bh = 4'h0;
    sc = fld[1];
    meas(4'h0, 4'h0, 4'h1);
    chk({7'h0, st_shut}, 8'h00, "shutdown count step");
    meas(4'h0, 4'h0, 4'h1);
    rchk(TLSR_ADDR_SHUTDOWN, 8'h01);
    bh = 4'hF;
    cyc(2);
    chk({6'h0, st_shut, shut_n}, 8'h01, "count two off");
    bh = 4'h0;
    sc = 3'h0;
    $display("test shutdown flags done");
    cm = 1'b1;
    meas(4'h4, 4'h0, 4'h0);
    chk({7'h0, st_high}, 8'h01, "comparator set");
    meas(4'h0, 4'h0, 4'h0);
    chk({7'h0, st_high}, 8'h00, "comparator follow");
    cm = 1'b0;
    fork
      u_host.reg_read(TLSR_ADDR_HIGH, d);
      meas(4'h8, 4'h0, 4'h0);
    join
    chk(d, 8'h00, "read before set");
    chk({7'h0, st_high}, 8'h01, "set beats clear");
    rchk(TLSR_ADDR_HIGH, 8'h08);
    $display("test comparator and collision done");
    give_verdict();
  end
endmodule
